/* File: logic/cbr_pkg.sv */
// Purpose: shared constants for the bulk report scheduler
// Assumes: 20 MHz system clock, plain register port
// Notes:   all offsets are byte addresses of 32-bit words
package cbr_pkg;
   // block count and widths
   localparam int NBLK = 4;
   localparam int AW = 8;
   localparam int DW = 32;
   localparam int IDW = 11;
   // global register offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_BASE_ID = 8'h04;
   localparam logic [7:0] OFS_PERIOD = 8'h08;
   localparam logic [7:0] OFS_MSG_GAP = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   // per-block window: base plus 16 bytes per block
   localparam logic [7:0] OFS_BLK0 = 8'h20;
   localparam logic [7:0] BLK_STEP = 8'h10;
   localparam logic [1:0] FLD_START = 2'h0;
   localparam logic [1:0] FLD_ENADDR = 2'h1;
   localparam logic [1:0] FLD_STRIDE = 2'h2;
   localparam logic [1:0] FLD_COUNT = 2'h3;
   // bit positions
   localparam int CTRL_EN_BIT = 0;
   localparam int STAT_BUSY_BIT = 0;
   // id offset of the first bulk block
   localparam logic [IDW-1:0] BULK_ID_OFS = 11'h040;
   // reset values
   localparam logic [31:0] RST_BASE_ID = 32'h0000_0100;
   localparam logic [31:0] RST_PERIOD = 32'h0007_A120;
   localparam logic [31:0] RST_GAP = 32'h0000_03E8;
   // timing: one microsecond in clock cycles
   localparam int CLK_MHZ = 20;
   localparam int US_NS = 1000;
   localparam int CLK_NS = 50;
   localparam int CYC_PER_US = US_NS / CLK_NS;
endpackage : cbr_pkg

/* File: logic/cbr_cfg_mem.sv */
// Purpose: small configuration store for the bulk report table
// Assumes: one write port, one read port, registered read data
// Notes:   holds four words per bulk block
`timescale 1ns/10ps
`default_nettype none
module cbr_cfg_mem
(
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        wr_en,
   input  wire logic [3:0]  wr_addr,
   input  wire logic [31:0] wr_data,
   input  wire logic [3:0]  rd_addr,
   output logic      [31:0] rd_data
);
   // storage, cleared so blocks start disabled
   logic [31:0] mem_r [16];

   ////////////////////////////////////////////////////////////////////
   // write port and registered read
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < 16; i++)
            mem_r[i] <= 32'h0000_0000;
         rd_data <= 32'h0000_0000;
      end
      else
      begin
         if (wr_en)
            mem_r[wr_addr] <= wr_data;
         rd_data <= mem_r[rd_addr];
      end
   end
endmodule : cbr_cfg_mem
`default_nettype wire

/* File: logic/cbr_sched.sv */
// Purpose: schedules bulk register reports onto a frame request port
// Assumes: register space read over a port answered in the strobe's own cycle;
//          a CAN controller outside takes one frame per tx_req/tx_ack
// Notes:   individually mapped frames share the gap timer via ind_req
//
// The address map and strobed register access were decided locally.
`timescale 1ns/10ps
`default_nettype none
module cbr_sched
(
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   // software register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   // internal register space read port
   output logic             src_rd,
   output logic      [31:0] src_addr,
   input  wire logic [31:0] src_data,
   // individually mapped report frames from elsewhere
   input  wire logic        ind_req,
   input  wire logic [10:0] ind_id,
   input  wire logic [31:0] ind_data,
   output logic             ind_ack,
   // frame request to the CAN controller
   output logic             tx_req,
   output logic      [10:0] tx_id,
   output logic      [31:0] tx_data,
   input  wire logic        tx_ack,
   // pass start pulse, for individual report sources
   output logic             pass_start
);
   // scheduler states
   typedef enum logic [3:0] {
      ST_IDLE, ST_CFG_START, ST_CFG_EN, ST_CFG_STR, ST_CFG_CNT,
      ST_CFG_WAIT, ST_RD_EN, ST_RD_DATA, ST_SEND, ST_GAP, ST_NEXT
   } cbr_state_t;

   ////////////////////////////////////////////////////////////////////
   // decode helpers
   // block window address to table index
   function automatic logic [3:0] cbr_tbl_idx(input logic [7:0] a);
      logic [7:0] rel;
      rel = a - cbr_pkg::OFS_BLK0;
      return {rel[5:4], rel[3:2]};
   endfunction : cbr_tbl_idx

   // is the address inside the block window
   function automatic logic cbr_in_tbl(input logic [7:0] a);
      return (a >= cbr_pkg::OFS_BLK0) &&
             (a < (cbr_pkg::OFS_BLK0 + 8'h40)) && (a[1:0] == 2'b00);
   endfunction : cbr_in_tbl

   ////////////////////////////////////////////////////////////////////
   // control registers
   logic        en_r;       // reporting enable
   logic [10:0] base_id_r;  // base frame id
   logic [31:0] period_r;   // report period in microseconds
   logic [31:0] gap_r;      // inter-message gap in microseconds

   wire logic wr_ctrl = reg_wr && (reg_addr == cbr_pkg::OFS_CTRL);
   wire logic wr_base = reg_wr && (reg_addr == cbr_pkg::OFS_BASE_ID);
   wire logic wr_per  = reg_wr && (reg_addr == cbr_pkg::OFS_PERIOD);
   wire logic wr_gap  = reg_wr && (reg_addr == cbr_pkg::OFS_MSG_GAP);
   wire logic wr_tbl  = reg_wr && cbr_in_tbl(reg_addr);

   // control register writes
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         en_r      <= 1'b0;
         base_id_r <= cbr_pkg::RST_BASE_ID[10:0];
         period_r  <= cbr_pkg::RST_PERIOD;
         gap_r     <= cbr_pkg::RST_GAP;
      end
      else
      begin
         if (wr_ctrl)
            en_r <= reg_wdata[cbr_pkg::CTRL_EN_BIT];
         if (wr_base)
            base_id_r <= reg_wdata[10:0];
         if (wr_per)
            period_r <= reg_wdata;
         if (wr_gap)
            gap_r <= reg_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // bulk report table storage
   cbr_state_t  st_r;
   logic [1:0]  blk_r;       // current block
   logic [3:0]  mem_raddr;   // table read index
   logic [31:0] mem_rdata;   // table read data (registered)
   // software reads of the table share the port; scheduler has priority
   // only while fetching config, so a software read then returns the scheduler's word
   wire logic  sched_fetch = (st_r == ST_CFG_START) ||
                             (st_r == ST_CFG_EN) ||
                             (st_r == ST_CFG_STR);
   logic [1:0] fld_sel;
   assign fld_sel = (st_r == ST_CFG_START) ? cbr_pkg::FLD_START :
                    (st_r == ST_CFG_EN)    ? cbr_pkg::FLD_ENADDR :
                    (st_r == ST_CFG_STR)   ? cbr_pkg::FLD_STRIDE :
                                             cbr_pkg::FLD_COUNT;
   wire logic cnt_fetch = (st_r == ST_CFG_CNT);
   assign mem_raddr = (sched_fetch || cnt_fetch) ? {blk_r, fld_sel}
                                                 : cbr_tbl_idx(reg_addr);

   cbr_cfg_mem u_mem
   (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .wr_en   (wr_tbl),
      .wr_addr (cbr_tbl_idx(reg_addr)),
      .wr_data (reg_wdata),
      .rd_addr (mem_raddr),
      .rd_data (mem_rdata)
   );

   ////////////////////////////////////////////////////////////////////
   // microsecond tick and period timer
   logic [4:0]  us_div_r;    // cycles within one microsecond
   logic [31:0] per_cnt_r;   // microseconds into current period
   logic [31:0] gap_cnt_r;   // microseconds of gap elapsed
   wire logic   us_tick  = (us_div_r == 5'(cbr_pkg::CYC_PER_US - 1));
   wire logic   per_done = us_tick && (per_cnt_r + 32'h1 >= period_r);

   // microsecond prescaler and period counter
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         us_div_r  <= 5'h00;
         per_cnt_r <= 32'h0000_0000;
      end
      else
      begin
         us_div_r <= us_tick ? 5'h00 : us_div_r + 5'h01;
         // restart period while disabled so the first pass comes a full period after enable
         if (!en_r || per_done)
            per_cnt_r <= 32'h0000_0000;
         else if (us_tick)
            per_cnt_r <= per_cnt_r + 32'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // scheduler state
   logic [31:0] start_r;    // working data address
   logic [31:0] enaddr_r;   // working enable address
   logic [31:0] stride_r;   // block stride
   logic [31:0] left_r;     // elements left in block
   logic [10:0] id_r;       // id of current element
   logic        pend_r;     // a pass is owed
   logic        blk_off_r;  // block disabled by zero start
   logic        sel_ind_r;  // current frame is individual

   wire logic last_blk = (blk_r == 2'(cbr_pkg::NBLK - 1));
   wire logic gap_over = (gap_cnt_r >= gap_r);

   // next-state values for the walk
   logic [1:0] blk_nxt;
   assign blk_nxt = blk_r + 2'h1;

   // scheduler sequencing
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_r       <= ST_IDLE;
         blk_r      <= 2'h0;
         start_r    <= 32'h0000_0000;
         enaddr_r   <= 32'h0000_0000;
         stride_r   <= 32'h0000_0000;
         left_r     <= 32'h0000_0000;
         id_r       <= 11'h000;
         pend_r     <= 1'b0;
         blk_off_r  <= 1'b0;
         sel_ind_r  <= 1'b0;
         gap_cnt_r  <= 32'h0000_0000;
         src_rd     <= 1'b0;
         src_addr   <= 32'h0000_0000;
         tx_req     <= 1'b0;
         tx_id      <= 11'h000;
         tx_data    <= 32'h0000_0000;
         ind_ack    <= 1'b0;
         pass_start <= 1'b0;
      end
      else
      begin
         src_rd     <= 1'b0;
         ind_ack    <= 1'b0;
         pass_start <= 1'b0;
         // a period tick arriving while busy is kept, not lost
         if (en_r && per_done)
            pend_r <= 1'b1;
         if (st_r == ST_GAP && us_tick)
            gap_cnt_r <= gap_cnt_r + 32'h1;
         unique case (st_r)
            // wait for work, only while enabled
            ST_IDLE:
            begin
               if (en_r && ind_req)
               begin
                  sel_ind_r <= 1'b1;
                  tx_req    <= 1'b1;
                  tx_id     <= ind_id;
                  tx_data   <= ind_data;
                  ind_ack   <= 1'b1;
                  st_r      <= ST_SEND;
               end
               else if (en_r && (pend_r || per_done))
               begin
                  pend_r     <= 1'b0;
                  pass_start <= 1'b1;
                  blk_r      <= 2'h0;
                  id_r       <= base_id_r + cbr_pkg::BULK_ID_OFS;
                  st_r       <= ST_CFG_START;
               end
            end
            // fetch the four table words of the block
            ST_CFG_START: st_r <= ST_CFG_EN;
            ST_CFG_EN:
            begin
               start_r   <= mem_rdata;
               blk_off_r <= (mem_rdata == 32'h0000_0000);
               st_r      <= ST_CFG_STR;
            end
            ST_CFG_STR:
            begin
               enaddr_r <= mem_rdata;
               st_r     <= ST_CFG_CNT;
            end
            ST_CFG_CNT:
            begin
               stride_r <= mem_rdata;
               st_r     <= ST_CFG_WAIT;
            end
            ST_CFG_WAIT:
            begin
               left_r <= mem_rdata;
               if (blk_off_r || mem_rdata == 32'h0000_0000)
               begin
                  // a disabled block still advances id by count
                  id_r <= id_r + mem_rdata[10:0];
                  st_r <= ST_NEXT;
               end
               else
               begin
                  src_rd   <= 1'b1;
                  src_addr <= enaddr_r;
                  st_r     <= ST_RD_EN;
               end
            end
            // enable value arrives in the read strobe's own cycle
            ST_RD_EN:
            begin
               if (src_data != 32'h0000_0000)
               begin
                  src_rd   <= 1'b1;
                  src_addr <= start_r;
                  st_r     <= ST_RD_DATA;
               end
               else
               begin
                  // skipped element keeps its id slot
                  st_r <= ST_NEXT;
               end
            end
            ST_RD_DATA:
            begin
               // same frame form as individual reports
               sel_ind_r <= 1'b0;
               tx_req    <= 1'b1;
               tx_id     <= id_r;
               tx_data   <= src_data;
               st_r      <= ST_SEND;
            end
            // hold the request until the controller takes it
            ST_SEND:
            begin
               if (tx_ack)
               begin
                  tx_req    <= 1'b0;
                  gap_cnt_r <= 32'h0000_0000;
                  st_r      <= ST_GAP;
               end
            end
            // pause in microseconds after each frame
            ST_GAP:
            begin
               if (gap_over)
                  st_r <= sel_ind_r ? ST_IDLE : ST_NEXT;
            end
            ST_NEXT:
            begin
               if (!blk_off_r && left_r > 32'h1)
               begin
                  left_r   <= left_r - 32'h1;
                  id_r     <= id_r + 11'h001;
                  start_r  <= start_r + stride_r;
                  enaddr_r <= enaddr_r + stride_r;
                  src_rd   <= 1'b1;
                  src_addr <= enaddr_r + stride_r;
                  st_r     <= ST_RD_EN;
               end
               else
               begin
                  if (!blk_off_r && left_r != 32'h0)
                     id_r <= id_r + 11'h001;
                  blk_off_r <= 1'b0;
                  left_r    <= 32'h0000_0000;
                  blk_r     <= blk_nxt;
                  st_r      <= last_blk ? ST_IDLE : ST_CFG_START;
               end
            end
            default: st_r <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // register read data, valid the cycle after the read strobe
   logic       rd_tbl_r;    // last read hit the table
   logic [31:0] rd_hold_r;  // plain register read value
   wire logic busy = (st_r != ST_IDLE);
   logic [31:0] rd_mux;
   assign rd_mux =
      (reg_addr == cbr_pkg::OFS_CTRL)    ? {31'h0, en_r} :
      (reg_addr == cbr_pkg::OFS_BASE_ID) ? {21'h0, base_id_r} :
      (reg_addr == cbr_pkg::OFS_PERIOD)  ? period_r :
      (reg_addr == cbr_pkg::OFS_MSG_GAP) ? gap_r :
      (reg_addr == cbr_pkg::OFS_STATUS)  ? {29'h0, blk_r, busy} :
                                           32'h0000_0000;

   // capture read source
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rd_tbl_r  <= 1'b0;
         rd_hold_r <= 32'h0000_0000;
      end
      else
      begin
         rd_tbl_r  <= reg_rd && cbr_in_tbl(reg_addr);
         rd_hold_r <= reg_rd ? rd_mux : 32'h0000_0000;
      end
   end
   // table word comes out of the memory register directly
   assign reg_rdata = rd_tbl_r ? mem_rdata : rd_hold_r;
endmodule : cbr_sched
`default_nettype wire

/* File: tb/cbr_sched_chk.sv */
// Purpose: port assertions for the bulk report scheduler
// Assumes: gap and enable settings shadowed from register writes
// Notes:   bound to every cbr_sched instance
`timescale 1ns/10ps
`default_nettype none
module cbr_sched_chk
(
   input wire logic        clk_sys,
   input wire logic        rst_n,
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        src_rd,
   input wire logic        ind_req,
   input wire logic        ind_ack,
   input wire logic        tx_req,
   input wire logic [10:0] tx_id,
   input wire logic [31:0] tx_data,
   input wire logic        tx_ack,
   input wire logic        pass_start
);
   logic [31:0] gap_r;   // shadow of the gap setting
   logic        en_r;    // shadow of the enable flag
   logic [31:0] since_r; // cycles since last accept, saturating
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   //////////////////////////////////////////////
   // shadows follow software writes; counter starts saturated
   // so the first frame after reset is not taken for a short gap
   always_ff @(posedge clk_sys or negedge rst_n)
      if (!rst_n)
      begin
         gap_r   <= cbr_pkg::RST_GAP;
         en_r    <= 1'b0;
         since_r <= 32'hFFFF_FFFF;
      end
      else
      begin
         if (reg_wr && reg_addr == cbr_pkg::OFS_MSG_GAP)
            gap_r <= reg_wdata;
         if (reg_wr && reg_addr == cbr_pkg::OFS_CTRL)
            en_r <= reg_wdata[cbr_pkg::CTRL_EN_BIT];
         if (tx_req && tx_ack)
            since_r <= 32'h0;
         else if (since_r != 32'hFFFF_FFFF)
            since_r <= since_r + 32'h1;
      end
   //////////////////////////////////////////////
   a_tx_hold: assert property (
      tx_req && !tx_ack |=> tx_req && $stable(tx_id) && $stable(tx_data))
      else $error("frame changed before accept");
   a_tx_release: assert property (
      tx_req && tx_ack |=> !tx_req)
      else $error("frame request held after accept");
   a_src_pulse: assert property (src_rd ##1 src_rd |=> !src_rd)
      else $error("more than two register reads in a row");
   a_ind_pulse: assert property (ind_ack |=> !ind_ack)
      else $error("individual accept longer than one cycle");
   a_ind_cause: assert property (ind_ack |-> ind_req)
      else $error("individual accept without request");
   a_pass_pulse: assert property (pass_start |=> !pass_start)
      else $error("pass start longer than one cycle");
   a_pass_enabled: assert property (pass_start |-> en_r)
      else $error("pass started while reporting disabled");
   a_gap_length: assert property (
      $rose(tx_req) && gap_r != 32'h0 |->
      since_r >= (gap_r - 32'h1) * cbr_pkg::CYC_PER_US)
      else $error("pause between frames too short");
endmodule : cbr_sched_chk
bind cbr_sched cbr_sched_chk chk_u (.clk_sys, .rst_n, .reg_addr,
   .reg_wdata, .reg_wr, .src_rd, .ind_req, .ind_ack, .tx_req, .tx_id,
   .tx_data, .tx_ack, .pass_start);
`default_nettype wire

/* File: tb/cbr_far_model.sv */
// Purpose: register space and frame controller beside the scheduler
// Assumes: each read is answered within the strobe's own cycle
// Notes:   one chosen address reads zero to suppress an element
`timescale 1ns/10ps
`default_nettype none
module cbr_far_model
#(
   parameter logic [31:0] SKIP_ADDR = 32'h2006 // reads as zero
)
(
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        src_rd,
   input  wire logic [31:0] src_addr,
   output logic      [31:0] src_data,
   input  wire logic        tx_req,
   output logic             tx_ack,
   input  wire logic [3:0]  ack_dly
);
   logic [3:0] wait_r; // cycles the frame has waited
   //////////////////////////////////////////////
   // the scheduler takes the word at the edge that ends its strobe,
   // so answer in that cycle; the idle word is zero, so a word taken
   // a cycle late shows up as a skipped or a wrong frame
   always_comb
      if (!src_rd)
         src_data = 32'h0;
      else if (src_addr == SKIP_ADDR)
         // zero enable word at the skip address
         src_data = 32'h0;
      else
         src_data = {src_addr[15:0], ~src_addr[15:0]};
   // accept each frame after ack_dly cycles, one-cycle pulse
   always_ff @(posedge clk_sys or negedge rst_n)
      if (!rst_n)
      begin
         tx_ack <= 1'b0;
         wait_r <= 4'h0;
      end
      else if (tx_req && !tx_ack && wait_r >= ack_dly)
      begin
         tx_ack <= 1'b1;
         wait_r <= 4'h0;
      end
      else
      begin
         tx_ack <= 1'b0;
         wait_r <= (tx_req && !tx_ack) ? wait_r + 4'h1 : 4'h0;
      end
endmodule : cbr_far_model
`default_nettype wire

/* File: tb/cbr_sched_tb.sv */
// Purpose: self-checking bench for the bulk report scheduler
// Assumes: far model answers reads and accepts frames
// Notes:   period cut to 30 us so passes come quickly
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) chk(32'(g), 32'(e))
module cbr_sched_tb;
   logic        clk_sys, rst_n;      // clock, active-low reset
   logic [7:0]  reg_addr;            // software port
   logic [31:0] reg_wdata, reg_rdata;
   logic        reg_wr, reg_rd;
   logic        src_rd;              // register space port
   logic [31:0] src_addr, src_data;
   logic        ind_req, ind_ack;    // individual frame port
   logic [10:0] ind_id, tx_id;
   logic [31:0] ind_data, tx_data;
   logic        tx_req, tx_ack, pass_start;
   logic [3:0]  ack_dly;             // controller accept delay
   int error_cnt = 0;
   int samples_checked = 0;
   int cyc = 0, t_ack = 0, t_pass = 0, n_pass = 0, n_src = 0;
   int i, t1, p;
   logic        tx_q = 1'b0;         // request seen last cycle
   logic [10:0] fid_q [$];           // accepted frame ids
   logic [31:0] fdat_q [$];          // accepted frame data
   int          gap_q [$];           // cycles from accept to request
   // table: start, enable address, stride, count per block
   // disabled block 1 spans two sixteen-cell groups
   // disabled block 3 one set of eight thermistors
   logic [31:0] cfg [16] = '{32'h1000, 32'h2000, 32'h6, 32'h4,
      32'h0, 32'h0, 32'h0, 32'h20, 32'h3000, 32'h3000, 32'h4, 32'h2,
      32'h0, 32'h0, 32'h0, 32'h8};
   logic [31:0] rv [5] = '{32'h0, cbr_pkg::RST_BASE_ID,
      cbr_pkg::RST_PERIOD, cbr_pkg::RST_GAP, 32'h0};
   logic [10:0] id1 [5] = '{11'h140, 11'h142, 11'h143, 11'h164, 11'h165};
   logic [31:0] ad1 [5] = '{32'h1000, 32'h100C, 32'h1012, 32'h3000,
      32'h3004};
   logic [10:0] id2 [5] = '{11'h240, 11'h262, 11'h263, 11'h0, 11'h0};
   logic [31:0] ad2 [5] = '{32'h1000, 32'h3000, 32'h3004, 32'h0, 32'h0};
   cbr_sched dut_u (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .src_rd, .src_addr, .src_data, .ind_req,
      .ind_id, .ind_data, .ind_ack, .tx_req, .tx_id, .tx_data, .tx_ack,
      .pass_start);
   cbr_far_model far_u (.clk_sys, .rst_n, .src_rd, .src_addr,
      .src_data, .tx_req, .tx_ack, .ack_dly);
   //////////////////////////////////////////////
   initial
   begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   // monitor: frames, gaps, passes and register-space reads
   always @(posedge clk_sys)
   begin
      cyc = cyc + 1;
      if (pass_start)
      begin
         n_pass = n_pass + 1;
         t_pass = cyc;
         n_src = 0;
      end
      else if (src_rd)
         n_src = n_src + 1;
      if (tx_req && !tx_q)
         gap_q.push_back(cyc - t_ack);
      if (tx_req && tx_ack)
      begin
         t_ack = cyc;
         fid_q.push_back(tx_id);
         fdat_q.push_back(tx_data);
      end
      tx_q = tx_req;
   end
   //////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : report_and_stop
   task automatic give_up();
      `CHK(1'b0, 1'b1);
      report_and_stop();
   endtask : give_up
   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : reg_write
   task automatic reg_read(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      `CHK(reg_rdata, e);
   endtask : reg_read
   task automatic wait_frame();
      for (int k = 0; k < 400 && fid_q.size() == 0; k++)
         @(posedge clk_sys);
      if (fid_q.size() == 0)
         give_up();
   endtask : wait_frame
   // one pass: n frames expected, ns register reads, gaps in lo..hi
   task automatic run_pass(input logic [10:0] id [5],
      input logic [31:0] ad [5], input int n, ns, lo, hi);
      int k, g;
      k = n_pass;
      for (int w = 0; w < 2000 && n_pass == k; w++)
         @(posedge clk_sys);
      if (n_pass == k)
         give_up();
      for (int j = 0; j < n; j++)
      begin
         wait_frame();
         `CHK(fid_q.pop_front(), id[j]);
         `CHK(fdat_q.pop_front(), {ad[j][15:0], ~ad[j][15:0]});
         g = gap_q.pop_front();
         if (j > 0)
            `CHK(g >= lo && g <= hi, 1'b1);
      end
      repeat (40) @(posedge clk_sys);
      `CHK(fid_q.size(), 0);
      `CHK(n_src, ns);
   endtask : run_pass
   //////////////////////////////////////////////
   initial
   begin
      rst_n = 1'b0;
      {reg_wr, reg_rd, ind_req, reg_addr, reg_wdata} = '0;
      {ind_id, ind_data, ack_dly} = '0;
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      for (i = 0; i < 5; i++)
         reg_read(8'(4 * i), rv[i]);
      reg_write(8'h14, 32'hFFFF_FFFF);
      reg_read(8'h14, 32'h0);
      for (i = 0; i < 16; i++)
         reg_write(cbr_pkg::OFS_BLK0 + 8'(4 * i), cfg[i]);
      for (i = 0; i < 16; i++)
         reg_read(cbr_pkg::OFS_BLK0 + 8'(4 * i), cfg[i]);
      reg_write(cbr_pkg::OFS_PERIOD, 32'd30);
      reg_write(cbr_pkg::OFS_MSG_GAP, 32'h0);
      reg_write(cbr_pkg::OFS_CTRL, 32'h1);
      run_pass(id1, ad1, 5, 11, 1, 30);
      t1 = t_pass;
      // slow controller, new base, shorter block 0, 3 us pause
      ack_dly <= 4'h6;
      reg_write(cbr_pkg::OFS_BASE_ID, 32'h200);
      reg_write(cbr_pkg::OFS_BLK0 + 8'hC, 32'h2);
      reg_write(cbr_pkg::OFS_MSG_GAP, 32'h3);
      run_pass(id2, ad2, 3, 7, 40, 110);
      `CHK(t_pass - t1 >= 580 && t_pass - t1 <= 620, 1'b1);
      // passes held off; two individual frames in a row share the pause
      reg_write(cbr_pkg::OFS_PERIOD, 32'h7FFF_FFFF);
      @(posedge clk_sys);
      ind_id <= 11'h123;
      ind_data <= 32'h0BAD_F00D;
      ind_req <= 1'b1;
      for (p = 0; p < 2; p++)
      begin
         i = 0;
         do
         begin
            @(posedge clk_sys);
            #1;
            i++;
         end
         while (i < 300 && ind_ack !== 1'b1);
         `CHK(ind_ack, 1'b1);
         @(posedge clk_sys);
      end
      ind_req <= 1'b0;
      for (p = 0; p < 2; p++)
      begin
         wait_frame();
         `CHK(fid_q.pop_front(), 11'h123);
         `CHK(fdat_q.pop_front(), 32'h0BAD_F00D);
         i = gap_q.pop_front();
      end
      `CHK(i >= 40 && i <= 110, 1'b1);
      // disabled: no pass and no frame although the period runs out
      reg_write(cbr_pkg::OFS_CTRL, 32'h0);
      reg_write(cbr_pkg::OFS_PERIOD, 32'd30);
      p = n_pass;
      repeat (700) @(posedge clk_sys);
      `CHK(n_pass, p);
      `CHK(fid_q.size(), 0);
      report_and_stop();
   end
endmodule : cbr_sched_tb
`default_nettype wire
